//--- shared/pwm_skip_pkg.sv
/*
 * Shared constants for the pulse-skip / over-current PWM control logic.
 * Assumes a 20 MHz logic clock and one-bit comparator verdicts from the
 * analog front end, already synchronous to that clock.
 */
package pwm_skip_pkg;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CLK_HZ = 20000000;
    localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
    // Hiccup recovery length in PWM clock periods
    localparam int RECOVERY_PERIODS = 16100;
    // Minimum on-time used when pulses are skipped, in ns
    localparam int MIN_ON_NS = 250;
    localparam int MIN_ON_CYCLES =
        (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Over-current sample point before on-time end (positive sensing), ns
    localparam int PRE_END_NS = 100;
    localparam int PRE_END_CYCLES =
        (PRE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic RST_POWER_GOOD = 1'b0;
    localparam logic RST_STARTUP = 1'b1;

    // ********************************************************
    // Controller states
    // ********************************************************
    typedef enum logic [1:0] {
        ST_STARTUP = 2'b00,
        ST_RUN = 2'b01,
        ST_RECOVER = 2'b10
    } ctrl_state_t;

endpackage

//--- rtl/pwm_event_counter.sv
/*
 * Up-counter that counts enabled events from a start pulse until a
 * terminal count and then flags done for one cycle.
 * Assumes start and tick are synchronous single-cycle levels.
 */
`timescale 1ns/100ps
module pwm_event_counter #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Control
    input wire logic start,
    input wire logic tick,
    input wire logic [WIDTH-1:0] terminal,
    // Status
    output logic busy,
    output logic done
);

    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;
    logic busy_q;
    logic busy_d;
    logic done_q;
    logic done_d;

    always_comb
    begin
        count_d = count_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (start)
        begin
            count_d = '0;
            busy_d = 1'b1;
        end
        else if (busy_q && tick)
        begin
            if (count_q == terminal - WIDTH'(1))
            begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
            count_d = count_q + WIDTH'(1);
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign busy = busy_q;
    assign done = done_q;

endmodule // pwm_event_counter

//--- rtl/pwm_skip_overcurrent_ctrl.sv
/*
 * PWM control logic: period start, comparator turn-off, pulse skipping,
 * over-current / overload detection with hiccup recovery, power good.
 * Assumes all comparator verdicts are synchronous to mclk and that the
 * PWM clock arrives as a level on pwm_clock_in whose rising edge starts
 * each period. Drivers outside are active high.
 */

// Functional notes
// - Two modes exist: standard fixed-frequency PWM and pulse skipping.
// - Ramp reaching min of error amp and duty limit ends high-side pulse.
// - Error amp 1.5V above duty limit starts the same recovery cycle.
// - Skipping only with pulse_skip_enable set; else standard after start.
// - Start-up forces pulse skipping regardless of pulse_skip_enable.
// - Forced start-up skipping ends when feedback exceeds 90% of reference and soft-start is done.
// - Buck (polarity one) skips pulses only while running asynchronous.
// - Below skip threshold, mask set pulses; emit aligned minimum pulses.
// - High-side pulse turns on at PWM clock rising edge.
// - Polarity one means negative sensing (buck), zero positive sensing.
// - Over-current turns both drives off 16100 periods, then soft-start.
// - Sample after pulse end for polarity one, before on-time end otherwise.
// - Polarity one qualifies detection by switch node below 0V first.
// - Duty-limit overload protection stays active at all times.
// - Over-current drops power good until recovery and soft-start end.
`timescale 1ns/100ps
module pwm_skip_overcurrent_ctrl #(
    parameter int RECOVERY_LEN = pwm_skip_pkg::RECOVERY_PERIODS,
    parameter int MIN_ON_LEN = pwm_skip_pkg::MIN_ON_CYCLES,
    parameter int PRE_END_LEN = pwm_skip_pkg::PRE_END_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Timing from oscillator and ramp
    input wire logic pwm_clock_in,
    input wire logic ramp_at_limit,
    input wire logic ramp_near_limit,
    // Analog comparator verdicts
    input wire logic comp_over_limit,
    input wire logic comp_below_skip,
    input wire logic feedback_above_90,
    input wire logic current_sense_trip,
    input wire logic switch_node_below_zero,
    input wire logic soft_start_done,
    // Configuration
    input wire logic pulse_skip_enable,
    input wire logic current_sense_polarity,
    input wire logic async_mode,
    // Drives and status
    output logic high_side_drive,
    output logic low_side_drive,
    output logic power_good_flag,
    output logic soft_start_restart,
    output logic skip_mode_active,
    output logic recovery_active
);

    // ********************************************************
    // State and registers
    // ********************************************************
    pwm_skip_pkg::ctrl_state_t state_q;
    pwm_skip_pkg::ctrl_state_t state_d;
    logic clk_prev_q;
    logic clk_prev_d;
    logic hs_q;
    logic hs_d;
    logic ls_q;
    logic ls_d;
    logic pg_q;
    logic pg_d;
    logic restart_q;
    logic restart_d;
    logic sw_armed_q;
    logic sw_armed_d;
    logic post_sample_q;
    logic post_sample_d;
    logic min_pulse_q;
    logic min_pulse_d;
    logic [15:0] on_cnt_q;
    logic [15:0] on_cnt_d;

    logic period_start;
    logic skip_allowed;
    logic mask_set;
    logic oc_hit;
    logic fault;
    logic rec_start;
    logic rec_busy;
    logic rec_done;

    // ********************************************************
    // Recovery counter
    // ********************************************************
    // Counts PWM periods, not mclk cycles, so hiccup length follows the
    // oscillator setting just as the analog part would.
    pwm_event_counter #(
        .WIDTH(16)
    ) u_recovery (
        .mclk(mclk),
        .reset_n(reset_n),
        .start(rec_start),
        .tick(period_start),
        .terminal(16'(RECOVERY_LEN)),
        .busy(rec_busy),
        .done(rec_done)
    );

    // ********************************************************
    // Mode and fault decode
    // ********************************************************
    assign period_start = pwm_clock_in && !clk_prev_q;

    always_comb
    begin
        // Outside start-up, buck sensing only skips while asynchronous
        skip_allowed = (state_q == pwm_skip_pkg::ST_STARTUP)
            || (pulse_skip_enable
                && (!current_sense_polarity || async_mode));
        mask_set = skip_allowed && comp_below_skip;
        // Negative sensing: sample once the pulse has ended, and only after
        // the switch node went below ground in this cycle
        if (current_sense_polarity)
        begin
            oc_hit = current_sense_trip && post_sample_q
                && (sw_armed_q || switch_node_below_zero);
        end
        else
        begin
            oc_hit = current_sense_trip && hs_q
                && (ramp_near_limit
                    || on_cnt_q >= 16'(PRE_END_LEN));
        end
        // Overload check is independent of sensing windows
        fault = oc_hit || comp_over_limit;
        rec_start = (state_q != pwm_skip_pkg::ST_RECOVER) && fault;
    end

    // ********************************************************
    // Pulse generation and protection
    // ********************************************************
    always_comb
    begin
        state_d = state_q;
        clk_prev_d = pwm_clock_in;
        hs_d = hs_q;
        ls_d = ls_q;
        pg_d = pg_q;
        restart_d = 1'b0;
        sw_armed_d = sw_armed_q || switch_node_below_zero;
        post_sample_d = 1'b0;
        min_pulse_d = min_pulse_q;
        on_cnt_d = hs_q ? on_cnt_q + 16'(1) : 16'(0);
        case (state_q)
            pwm_skip_pkg::ST_STARTUP,
            pwm_skip_pkg::ST_RUN:
            begin
                if (state_q == pwm_skip_pkg::ST_STARTUP && feedback_above_90
                    && soft_start_done)
                begin
                    state_d = pwm_skip_pkg::ST_RUN;
                end
                if (period_start)
                begin
                    // Skipped periods still emit a minimum pulse on the
                    // clock edge so the output stays frequency-locked.
                    hs_d = 1'b1;
                    ls_d = 1'b0;
                    min_pulse_d = mask_set;
                    sw_armed_d = 1'b0;
                end
                else if (hs_q)
                begin
                    if (min_pulse_q)
                    begin
                        if (on_cnt_q >= 16'(MIN_ON_LEN) - 16'(1))
                        begin
                            hs_d = 1'b0;
                        end
                    end
                    else if (ramp_at_limit)
                    begin
                        hs_d = 1'b0;
                    end
                    if (!hs_d)
                    begin
                        // Low side off while skipping or asynchronous, on otherwise
                        ls_d = !(skip_allowed || async_mode);
                        post_sample_d = 1'b1;
                    end
                end
                pg_d = (state_q == pwm_skip_pkg::ST_RUN) && feedback_above_90;
                if (rec_start)
                begin
                    // Cut both drives in the detecting cycle
                    state_d = pwm_skip_pkg::ST_RECOVER;
                    hs_d = 1'b0;
                    ls_d = 1'b0;
                    pg_d = 1'b0;
                    min_pulse_d = 1'b0;
                end
            end
            pwm_skip_pkg::ST_RECOVER:
            begin
                hs_d = 1'b0;
                ls_d = 1'b0;
                pg_d = 1'b0;
                if (rec_done)
                begin
                    // Soft-start runs again; power good waits for it
                    state_d = pwm_skip_pkg::ST_STARTUP;
                    restart_d = 1'b1;
                end
            end
            default:
            begin
                state_d = pwm_skip_pkg::ST_RECOVER;
                hs_d = 1'b0;
                ls_d = 1'b0;
                pg_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= pwm_skip_pkg::ST_STARTUP;
            clk_prev_q <= 1'b0;
            hs_q <= 1'b0;
            ls_q <= 1'b0;
            pg_q <= pwm_skip_pkg::RST_POWER_GOOD;
            restart_q <= 1'b0;
            sw_armed_q <= 1'b0;
            post_sample_q <= 1'b0;
            min_pulse_q <= 1'b0;
            on_cnt_q <= 16'h0000;
        end
        else
        begin
            state_q <= state_d;
            clk_prev_q <= clk_prev_d;
            hs_q <= hs_d;
            ls_q <= ls_d;
            pg_q <= pg_d;
            restart_q <= restart_d;
            sw_armed_q <= sw_armed_d;
            post_sample_q <= post_sample_d;
            min_pulse_q <= min_pulse_d;
            on_cnt_q <= on_cnt_d;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign high_side_drive = hs_q;
    assign low_side_drive = ls_q;
    assign power_good_flag = pg_q;
    assign soft_start_restart = restart_q;
    assign skip_mode_active = skip_allowed;
    assign recovery_active = rec_busy;

endmodule // pwm_skip_overcurrent_ctrl

//--- tb/pwm_skip_ctrl_properties.sv
/* Port checker for the PWM control block.
   Assumes one clock domain and a bind onto the top module. */
`timescale 1ns/100ps
module pwm_skip_ctrl_properties (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Inputs
    input wire logic pwm_clock_in,
    input wire logic ramp_at_limit,
    input wire logic comp_over_limit,
    input wire logic comp_below_skip,
    input wire logic current_sense_trip,
    input wire logic pulse_skip_enable,
    input wire logic current_sense_polarity,
    input wire logic async_mode,
    // Outputs
    input wire logic high_side_drive,
    input wire logic low_side_drive,
    input wire logic power_good_flag,
    input wire logic soft_start_restart,
    input wire logic skip_mode_active,
    input wire logic recovery_active
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    // ****
    // Properties
    // ****
    // A fault one cycle back may already hold the state in recovery
    period_start_a: assert property (
        $rose(pwm_clock_in) && !recovery_active && !comp_over_limit
        && !$past(comp_over_limit) && !$past(current_sense_trip)
        |-> ##[1:2] high_side_drive)
        else $error("pulse missing after period start");
    ramp_end_a: assert property (
        high_side_drive && ramp_at_limit && !comp_below_skip
        |-> ##[1:2] !high_side_drive)
        else $error("pulse not ended by ramp");
    min_on_a: assert property (
        $rose(high_side_drive) && skip_mode_active && comp_below_skip
        |-> high_side_drive[*4] ##[1:3] !high_side_drive)
        else $error("minimum on-time wrong");
    overload_drop_a: assert property (
        comp_over_limit && !recovery_active
        |-> ##2 (!high_side_drive && !low_side_drive && !power_good_flag))
        else $error("overload did not drop drives");
    overload_enter_a: assert property (
        comp_over_limit && !recovery_active |-> ##[2:3] recovery_active)
        else $error("overload did not start recovery");
    pos_trip_a: assert property (
        $rose(high_side_drive) && current_sense_trip
        && !current_sense_polarity && !recovery_active
        |-> ##[2:5] (!high_side_drive && !power_good_flag))
        else $error("on-time current trip missed");
    recovery_off_a: assert property (
        recovery_active
        |-> !high_side_drive && !low_side_drive && !power_good_flag)
        else $error("drive active during recovery");
    // Busy falls one cycle before the state leaves recovery
    restart_end_a: assert property (
        soft_start_restart |-> $past(recovery_active, 2))
        else $error("restart outside recovery");
    skip_enable_a: assert property (
        power_good_flag && !pulse_skip_enable
        && !$past(comp_over_limit) && !$past(current_sense_trip)
        |-> !skip_mode_active)
        else $error("skipping without enable");
    skip_buck_a: assert property (
        power_good_flag && current_sense_polarity
        && !async_mode && !$past(comp_over_limit)
        && !$past(current_sense_trip) |-> !skip_mode_active)
        else $error("buck skipping while synchronous");
    cover property ($rose(recovery_active));
    cover property (soft_start_restart);
    cover property ($rose(high_side_drive) && skip_mode_active);
endmodule // pwm_skip_ctrl_properties

//--- tb/gate_driver_model.sv
/* Gate drivers and power stage seen by the control block.
   Assumes active-high drives; short_load comes from the bench. */
`timescale 1ns/100ps
module gate_driver_model (
    // Clock
    input wire logic mclk,
    // Drives and bench control
    input wire logic high_side_drive,
    input wire logic low_side_drive,
    input wire logic short_load,
    input wire logic current_sense_polarity,
    // Sensed stage
    output logic switch_node_below_zero,
    output logic current_sense_trip
);
    logic [1:0] freewheel_q = 2'h0;

    // Inductor keeps the node below ground briefly after the pulse
    always_ff @(posedge mclk)
        freewheel_q <= high_side_drive ? 2'h3 : {1'h0, freewheel_q[1]};
    assign switch_node_below_zero = low_side_drive
        || (!high_side_drive && freewheel_q[0]);
    // Buck senses after the pulse, other stages during it
    assign current_sense_trip = short_load && (current_sense_polarity
        ? switch_node_below_zero : high_side_drive);
endmodule // gate_driver_model

//--- tb/tb_pwm_skip_overcurrent_ctrl.sv
/* Self-checking bench for the PWM control block.
   Assumes a 20 MHz clock and a recovery count shortened to 4. */
`timescale 1ns/100ps
module tb_pwm_skip_overcurrent_ctrl;
    // ****
    // Signals
    // ****
    logic mclk = 1'h0;
    logic reset_n = 1'h0;
    logic pwm_clock_in = 1'h0;
    logic ramp_at_limit = 1'h0;
    logic ramp_near_limit = 1'h0;
    logic comp_over_limit = 1'h0;
    logic comp_below_skip = 1'h1;
    logic feedback_above_90 = 1'h0;
    logic soft_start_done = 1'h0;
    logic pulse_skip_enable = 1'h0;
    logic current_sense_polarity = 1'h0;
    logic async_mode = 1'h0;
    logic short_load = 1'h0;
    logic restart_seen = 1'h0;
    logic current_sense_trip, switch_node_below_zero;
    logic high_side_drive, low_side_drive, power_good_flag;
    logic soft_start_restart, skip_mode_active, recovery_active;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;

    always #25 mclk = ~mclk;

    pwm_skip_overcurrent_ctrl #(.RECOVERY_LEN(4))
        pwm_skip_overcurrent_ctrl_inst (.mclk, .reset_n, .pwm_clock_in,
        .ramp_at_limit, .ramp_near_limit, .comp_over_limit,
        .comp_below_skip, .feedback_above_90, .current_sense_trip,
        .switch_node_below_zero, .soft_start_done, .pulse_skip_enable,
        .current_sense_polarity, .async_mode, .high_side_drive,
        .low_side_drive, .power_good_flag, .soft_start_restart,
        .skip_mode_active, .recovery_active);

    gate_driver_model gate_driver_model_inst (.mclk, .high_side_drive,
        .low_side_drive, .short_load, .current_sense_polarity,
        .switch_node_below_zero, .current_sense_trip);

    // The restart pulse lasts one cycle, so latch it
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (soft_start_restart === 1'h1)
            restart_seen <= 1'h1;
    end

    always @(negedge mclk)
        if (cycles == 8000)
        begin
            n_mismatch++;
            end_of_test();
        end

    // ****
    // Tasks
    // ****
    task automatic check(input logic seen, input logic exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t ns: seen %b expected %b", $time, seen, exp);
        end
    endtask

    task automatic period(input int on_len, input logic hs, input logic hs2,
        input logic ls);
        @(negedge mclk) pwm_clock_in = 1'h1;
        repeat (2) @(negedge mclk);
        check(high_side_drive, hs);
        repeat (on_len) @(negedge mclk);
        ramp_at_limit = 1'h1;
        repeat (2) @(negedge mclk);
        ramp_at_limit = 1'h0;
        pwm_clock_in = 1'h0;
        check(high_side_drive, hs2);
        check(low_side_drive, ls);
        repeat (10) @(negedge mclk);
        check(high_side_drive, 1'h0);
    endtask

    // Soft-start reruns after recovery, so its done level drops meanwhile
    task automatic recover;
        restart_seen = 1'h0;
        comp_over_limit = 1'h1;
        soft_start_done = 1'h0;
        repeat (3) period(2, 1'h0, 1'h0, 1'h0);
        comp_over_limit = 1'h0;
        check(restart_seen, 1'h0);
        check(power_good_flag, 1'h0);
        period(2, 1'h0, 1'h0, 1'h0);
        check(restart_seen, 1'h1);
        check(recovery_active, 1'h0);
        check(power_good_flag, 1'h0);
        soft_start_done = 1'h1;
        repeat (4) @(negedge mclk);
        check(power_good_flag, 1'h1);
    endtask

    task automatic t_startup;
        check(skip_mode_active, 1'h1);
        period(1, 1'h1, 1'h1, 1'h0);
        $display("startup test done");
    endtask

    task automatic t_run;
        comp_below_skip = 1'h0;
        feedback_above_90 = 1'h1;
        soft_start_done = 1'h1;
        repeat (4) @(negedge mclk);
        check(skip_mode_active, 1'h0);
        check(power_good_flag, 1'h1);
        period(3, 1'h1, 1'h0, 1'h1);
        pulse_skip_enable = 1'h1;
        #1 check(skip_mode_active, 1'h1);
        current_sense_polarity = 1'h1;
        #1 check(skip_mode_active, 1'h0);
        async_mode = 1'h1;
        #1 check(skip_mode_active, 1'h1);
        comp_below_skip = 1'h1;
        period(1, 1'h1, 1'h1, 1'h0);
        comp_below_skip = 1'h0;
        pulse_skip_enable = 1'h0;
        current_sense_polarity = 1'h0;
        async_mode = 1'h0;
        $display("run test done");
    endtask

    task automatic t_fault;
        short_load = 1'h1;
        @(negedge mclk) pwm_clock_in = 1'h1;
        repeat (8) @(negedge mclk);
        pwm_clock_in = 1'h0;
        short_load = 1'h0;
        check(high_side_drive, 1'h0);
        check(power_good_flag, 1'h0);
        check(recovery_active, 1'h1);
        recover();
        $display("on-time trip test done");
    endtask

    // Near-limit window trips before the on-time count would
    task automatic t_near;
        short_load = 1'h1;
        ramp_near_limit = 1'h1;
        @(negedge mclk) pwm_clock_in = 1'h1;
        repeat (2) @(negedge mclk);
        check(high_side_drive, 1'h0);
        check(recovery_active, 1'h1);
        pwm_clock_in = 1'h0;
        short_load = 1'h0;
        ramp_near_limit = 1'h0;
        recover();
        $display("pre-end trip test done");
    endtask

    task automatic t_overload;
        @(negedge mclk) comp_over_limit = 1'h1;
        @(negedge mclk) comp_over_limit = 1'h0;
        repeat (2) @(negedge mclk);
        check(power_good_flag, 1'h0);
        check(recovery_active, 1'h1);
        recover();
        $display("overload test done");
    endtask

    task automatic t_buck;
        current_sense_polarity = 1'h1;
        async_mode = 1'h1;
        short_load = 1'h1;
        period(3, 1'h1, 1'h0, 1'h0);
        short_load = 1'h0;
        check(recovery_active, 1'h1);
        recover();
        $display("buck trip test done");
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(negedge mclk);
        reset_n = 1'h1;
        t_startup();
        t_run();
        t_fault();
        t_near();
        t_overload();
        t_buck();
        end_of_test();
    end
endmodule // tb_pwm_skip_overcurrent_ctrl

bind pwm_skip_overcurrent_ctrl pwm_skip_ctrl_properties
    pwm_skip_ctrl_properties_inst (.mclk, .reset_n, .pwm_clock_in,
    .ramp_at_limit, .comp_over_limit, .comp_below_skip,
    .current_sense_trip, .pulse_skip_enable, .current_sense_polarity,
    .async_mode, .high_side_drive, .low_side_drive, .power_good_flag,
    .soft_start_restart, .skip_mode_active, .recovery_active);
